// *** core/can_receive_flag_status.sv ***
`timescale 1ns/1ps
// Behaviour
// - wake flag on bus activity while sleeping with wake enable set
// - wake request while flag set, unmasked
// - change flag when bus state changes
// - state fields frozen while change flag set
// - receiver state from receive count thresholds
// - receiver shows bus-off above 255 transmit
// - leaving bus-off returns receiver to its receive count state
// - transmitter state from transmit count thresholds
// - overrun flag on receive overrun
// - error request from change or overrun
// - full flag when message enters foreground
// - only correct messages load the foreground
// - full flag blocks the next shift
// - receive request while full flag set
// - write one clears, cause gone; zero ignored
// - init mode holds flags reset, ignores flag and mask writes
// - state fields are read only
module can_receive_flag_status
    import rx_flag_pkg::*;
(
    input  wire logic        I_REF_CLK,        // module clock
    input  wire logic        I_RESET,          // async reset, active high
    // register bus, AXI4-Lite slave
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // protocol engine side, same clock
    input  wire logic        I_BUS_ACTIVITY,   // activity seen on the bus
    input  wire logic        I_OVERRUN,        // receive overrun pulse
    input  wire logic        I_MSG_PENDING,    // fifo holds a message to shift
    input  wire logic        I_MSG_GOOD,       // that message was received correctly
    input  wire logic [8:0]  I_TX_ERROR_COUNT, // transmit error count
    input  wire logic [8:0]  I_RX_ERROR_COUNT, // receive error count
    input  wire logic        I_INIT_MODE_ACK,  // engine acknowledges init mode
    output logic             O_SHIFT,          // move fifo entry to foreground
    output logic             O_INIT_MODE_REQUEST,
    output logic             O_SLEEP,
    output logic             O_WAKE_IRQ,
    output logic             O_ERROR_IRQ,
    output logic             O_RX_IRQ
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {IDLE, RESP} bus_type;

    logic       wake_q,   wake_d;     // wake_event_flag
    logic       chg_q,    chg_d;      // bus_state_change_flag
    logic       ovr_q,    ovr_d;      // overrun_flag
    logic       full_q,   full_d;     // rx_full_flag
    logic [1:0] rxst_q,   rxst_d;     // rx_state_field
    logic [1:0] txst_q,   txst_d;     // tx_state_field
    logic [7:0] mask_q,   mask_d;     // per-flag enables, same layout
    logic [2:0] ctrl_q,   ctrl_d;     // wake enable, sleep, init request
    logic       aw_q,     aw_d;       // write address held
    logic       w_q,      w_d;        // write data held
    logic [7:0] awa_q,    awa_d;      // captured write address
    logic [7:0] wd_q,     wd_d;       // captured write byte
    logic       wstb_q,   wstb_d;     // low lane strobe
    bus_type    wst_q,    wst_d;      // write answer state
    bus_type    rst_q,    rst_d;      // read answer state
    logic [31:0] rdat_q,  rdat_d;     // read data register
    logic [1:0] bresp_q,  bresp_d;
    logic [1:0] rresp_q,  rresp_d;

    logic [1:0] enc_rx, enc_tx;       // live state codes
    logic       in_init;              // init requested and acknowledged
    logic       wr_go;                // write lands this cycle
    logic [7:0] clr;                  // write-one-clear bits
    logic       set_wake, set_chg, set_ovr, set_full;
    logic [7:0] flags;                // assembled status byte

    rx_state_encode u_enc (
        .i_rx_count (I_RX_ERROR_COUNT),
        .i_tx_count (I_TX_ERROR_COUNT),
        .o_rx_state (enc_rx),
        .o_tx_state (enc_tx)
    );

    assign in_init = ctrl_q[BIT_INIT_REQ] & I_INIT_MODE_ACK;
    assign flags   = {wake_q, chg_q, rxst_q, txst_q, ovr_q, full_q};
    assign wr_go   = aw_q & w_q & (wst_q == IDLE);

    // ----------------------------------------------------------------
    // flag logic
    // ----------------------------------------------------------------
    always_comb begin
        set_wake = ctrl_q[BIT_SLEEP] & ctrl_q[BIT_WAKE_EN] & I_BUS_ACTIVITY;
        set_chg  = (enc_rx != rxst_q) | (enc_tx != txst_q);
        set_ovr  = I_OVERRUN;
        set_full = I_MSG_PENDING & I_MSG_GOOD & ~full_q;
        clr = (wr_go && awa_q == ADDR_FLAGS && wstb_q) ? wd_q : 8'h00;
        // set term ORed last so it wins, except change and full: their set terms need the flag clear
        wake_d = (wake_q & ~clr[BIT_WAKE]) | set_wake;
        ovr_d  = (ovr_q & ~clr[BIT_OVERRUN]) | set_ovr;
        full_d = (full_q & ~clr[BIT_FULL]) | set_full;
        chg_d  = (chg_q & ~clr[BIT_CHANGE]) | (set_chg & ~chg_q);
        // leaving bus-off gives the receive count state via encoder
        if (!chg_q) begin
            rxst_d = enc_rx;
            txst_d = enc_tx;
        end else begin
            rxst_d = rxst_q;
            txst_d = txst_q;
        end
        // init holds flags, not state fields
        if (in_init) begin
            wake_d = FLAGS_RESET[BIT_WAKE];
            chg_d  = FLAGS_RESET[BIT_CHANGE];
            ovr_d  = FLAGS_RESET[BIT_OVERRUN];
            full_d = FLAGS_RESET[BIT_FULL];
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            wake_q <= 1'b0;
            chg_q  <= 1'b0;
            ovr_q  <= 1'b0;
            full_q <= 1'b0;
            rxst_q <= ST_OK;
            txst_q <= ST_OK;
        end else begin
            wake_q <= wake_d;
            chg_q  <= chg_d;
            ovr_q  <= ovr_d;
            full_q <= full_d;
            rxst_q <= rxst_d;
            txst_q <= txst_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs to engine and interrupt requests
    // ----------------------------------------------------------------
    // shift pulse sets full
    assign O_SHIFT             = set_full & ~in_init;
    assign O_INIT_MODE_REQUEST = ctrl_q[BIT_INIT_REQ];
    assign O_SLEEP             = ctrl_q[BIT_SLEEP];
    assign O_WAKE_IRQ  = wake_q & mask_q[BIT_WAKE];
    assign O_ERROR_IRQ = (chg_q & mask_q[BIT_CHANGE]) | (ovr_q & mask_q[BIT_OVERRUN]);
    assign O_RX_IRQ    = full_q & mask_q[BIT_FULL];

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    // one-deep capture; ready drops while a write is held so order is free
    assign O_AWREADY = ~aw_q;
    assign O_WREADY  = ~w_q;
    assign O_ARREADY = (rst_q == IDLE);
    assign O_BVALID  = (wst_q == RESP);
    assign O_RVALID  = (rst_q == RESP);
    assign O_BRESP   = bresp_q;
    assign O_RRESP   = rresp_q;
    assign O_RDATA   = rdat_q;

    always_comb begin
        // hold everything unless a branch below moves it
        aw_d    = aw_q;
        w_d     = w_q;
        awa_d   = awa_q;
        wd_d    = wd_q;
        wstb_d  = wstb_q;
        wst_d   = wst_q;
        bresp_d = bresp_q;
        mask_d  = mask_q;
        ctrl_d  = ctrl_q;
        rst_d   = rst_q;
        rdat_d  = rdat_q;
        rresp_d = rresp_q;
        // capture address and data independently
        if (I_AWVALID && !aw_q) begin
            aw_d = 1'b1;
            awa_d = I_AWADDR;
        end
        if (I_WVALID && !w_q) begin
            w_d = 1'b1;
            wd_d = I_WDATA[7:0];
            wstb_d = I_WSTRB[0];
        end
        // write lands, answer next cycle
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            wst_d = RESP;
            bresp_d = RESP_OKAY;
            case (awa_q)
                ADDR_FLAGS: ;
                ADDR_MASK: begin
                    // mask also frozen in init mode
                    if (wstb_q && !in_init) mask_d = wd_q;
                end
                ADDR_CTRL: begin
                    if (wstb_q) ctrl_d = wd_q[2:0];
                end
                ADDR_COUNTERS: ;
                default: bresp_d = RESP_SLVERR;
            endcase
        end else if (wst_q == RESP && I_BREADY) begin
            wst_d = IDLE;
        end
        if (in_init) mask_d = MASK_RESET;
        // read path
        if (rst_q == IDLE && I_ARVALID) begin
            rst_d = RESP;
            rresp_d = RESP_OKAY;
            case (I_ARADDR)
                ADDR_FLAGS:    rdat_d = {24'h000000, flags};
                ADDR_MASK:     rdat_d = {24'h000000, mask_q};
                ADDR_CTRL:     rdat_d = {28'h0000000, I_INIT_MODE_ACK, ctrl_q};
                ADDR_COUNTERS: rdat_d = {7'h00, I_TX_ERROR_COUNT, 7'h00, I_RX_ERROR_COUNT};
                default: begin
                    rdat_d = 32'h00000000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end else if (rst_q == RESP && I_RREADY) begin
            rst_d = IDLE;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            aw_q    <= 1'b0;
            w_q     <= 1'b0;
            awa_q   <= 8'h00;
            wd_q    <= 8'h00;
            wstb_q  <= 1'b0;
            wst_q   <= IDLE;
            rst_q   <= IDLE;
            rdat_q  <= 32'h00000000;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            mask_q  <= MASK_RESET;
            ctrl_q  <= 3'h0;
        end else begin
            aw_q    <= aw_d;
            w_q     <= w_d;
            awa_q   <= awa_d;
            wd_q    <= wd_d;
            wstb_q  <= wstb_d;
            wst_q   <= wst_d;
            rst_q   <= rst_d;
            rdat_q  <= rdat_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            mask_q  <= mask_d;
            ctrl_q  <= ctrl_d;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);

    a_wake_set: assert property (set_wake && !in_init |=> wake_q) else $error("wake flag not set");
    a_wake_irq: assert property (O_WAKE_IRQ == (wake_q && mask_q[BIT_WAKE]))
        else $error("wake request wrong");
    a_chg_set: assert property (!chg_q && !in_init && set_chg |=> chg_q)
        else $error("change flag missed");
    a_state_frozen: assert property (chg_q |=> $stable(rxst_q) && $stable(txst_q))
        else $error("state moved while pending");
    a_rx_encode: assert property (!chg_q && I_TX_ERROR_COUNT <= BUSOFF_LIMIT
        && I_RX_ERROR_COUNT > PASSIVE_LIMIT |=> rxst_q == ST_PASSIVE) else $error("rx state code wrong");
    a_busoff_rx: assert property (!chg_q && I_TX_ERROR_COUNT > BUSOFF_LIMIT
        |=> rxst_q == ST_BUSOFF && txst_q == ST_BUSOFF) else $error("bus-off not shown");
    a_busoff_exit: assert property (!chg_q && I_TX_ERROR_COUNT <= WARN_LIMIT
        && I_RX_ERROR_COUNT <= WARN_LIMIT |=> rxst_q == ST_OK) else $error("rx not ok");
    a_tx_encode: assert property (!chg_q && I_TX_ERROR_COUNT > WARN_LIMIT
        && I_TX_ERROR_COUNT <= PASSIVE_LIMIT |=> txst_q == ST_WARNING) else $error("tx state code wrong");
    a_ovr_set: assert property (I_OVERRUN && !in_init |=> ovr_q) else $error("overrun lost");
    a_full_block: assert property (full_q |-> !O_SHIFT) else $error("shift while full");
    a_full_good: assert property ($rose(full_q) |-> $past(I_MSG_GOOD)) else $error("bad message loaded");
    a_init_hold: assert property (in_init |=> !wake_q && !chg_q && !ovr_q && !full_q)
        else $error("flags live in init");

    c_full_clear: cover property (full_q ##[1:20] !full_q);
    c_busoff: cover property (txst_q == ST_BUSOFF);
    c_wake: cover property (O_WAKE_IRQ);
    c_error: cover property (O_ERROR_IRQ && O_RX_IRQ);
endmodule

// *** core/rx_flag_pkg.sv ***
package rx_flag_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses on the register bus)
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_FLAGS    = 8'h00;  // receive_flag_status
    localparam logic [7:0]  ADDR_MASK     = 8'h04;  // interrupt masks
    localparam logic [7:0]  ADDR_CTRL     = 8'h08;  // wake enable, sleep, init request
    localparam logic [7:0]  ADDR_COUNTERS = 8'h0C;  // error counters, read only
    // ----------------------------------------------------------------
    // receive_flag_status fields
    // ----------------------------------------------------------------
    localparam int BIT_WAKE    = 7;
    localparam int BIT_CHANGE  = 6;
    localparam int BIT_RXST_HI = 5;
    localparam int BIT_RXST_LO = 4;
    localparam int BIT_TXST_HI = 3;
    localparam int BIT_TXST_LO = 2;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_FULL    = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int BIT_WAKE_EN  = 0;
    localparam int BIT_SLEEP    = 1;
    localparam int BIT_INIT_REQ = 2;
    // ----------------------------------------------------------------
    // error-count thresholds and state codes
    // ----------------------------------------------------------------
    localparam logic [8:0] WARN_LIMIT    = 9'h060;  // 96
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;  // 127
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;  // 255
    localparam logic [1:0] ST_OK      = 2'h0;
    localparam logic [1:0] ST_WARNING = 2'h1;
    localparam logic [1:0] ST_PASSIVE = 2'h2;
    localparam logic [1:0] ST_BUSOFF  = 2'h3;
    // ----------------------------------------------------------------
    // bus answer codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** core/rx_state_encode.sv ***
`timescale 1ns/1ps
// maps the two error counters onto the receiver and transmitter state codes
module rx_state_encode
    import rx_flag_pkg::*;
(
    input  wire logic [8:0] i_rx_count,  // receive error count
    input  wire logic [8:0] i_tx_count,  // transmit error count
    output logic      [1:0] o_rx_state,  // receiver state code
    output logic      [1:0] o_tx_state   // transmitter state code
);
    // ----------------------------------------------------------------
    // combinational encoding
    // ----------------------------------------------------------------
    always_comb begin
        if (i_tx_count > BUSOFF_LIMIT) begin
            o_tx_state = ST_BUSOFF;
        end else if (i_tx_count > PASSIVE_LIMIT) begin
            o_tx_state = ST_PASSIVE;
        end else if (i_tx_count > WARN_LIMIT) begin
            o_tx_state = ST_WARNING;
        end else begin
            o_tx_state = ST_OK;
        end
        if (i_tx_count > BUSOFF_LIMIT) begin
            o_rx_state = ST_BUSOFF;
        end else if (i_rx_count > PASSIVE_LIMIT) begin
            o_rx_state = ST_PASSIVE;
        end else if (i_rx_count > WARN_LIMIT) begin
            o_rx_state = ST_WARNING;
        end else begin
            o_rx_state = ST_OK;
        end
    end
endmodule

// *** test/engine_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// protocol engine stand-in: counters, fifo head, bus events
// ------------------------------------------------------------
module engine_model (
    input  wire logic       i_clk,       // module clock
    input  wire logic       i_shift,     // head moved to foreground
    input  wire logic       i_init_req,  // init mode request
    input  wire logic       i_act,       // bench: activity level
    input  wire logic       i_ovr,       // bench: overrun level
    input  wire logic       i_push,      // bench: append a message
    input  wire logic       i_push_good, // bench: that message is correct
    input  wire logic [8:0] i_tx,        // bench: transmit count
    input  wire logic [8:0] i_rx,        // bench: receive count
    output logic            o_activity,  // activity seen on the bus
    output logic            o_overrun,   // overrun condition
    output logic            o_pending,   // fifo head valid
    output logic            o_good,      // fifo head correct
    output logic [8:0]      o_tx_count,  // transmit error count
    output logic [8:0]      o_rx_count,  // receive error count
    output logic            o_init_ack   // init acknowledge
);
    logic msg_q [$];  // correctness bit of each queued message
    initial begin
        {o_activity, o_overrun, o_pending, o_good, o_init_ack} = 5'h00;
        {o_tx_count, o_rx_count} = 18'h00000;
    end
    // head pops on a shift; a bad message is dropped after one cycle
    always @(posedge i_clk) begin
        if (o_pending && (i_shift || !o_good)) begin
            void'(msg_q.pop_front());
        end
        if (i_push) begin
            msg_q.push_back(i_push_good);
        end
        o_pending  <= (msg_q.size() > 0);
        // no head: keep the line moving so a stale value never looks valid
        o_good     <= (msg_q.size() > 0) ? msg_q[0] : ~o_good;
        o_activity <= i_act;
        o_overrun  <= i_ovr;
        o_tx_count <= i_tx;
        o_rx_count <= i_rx;
        o_init_ack <= i_init_req;  // ack one cycle behind request
    end
endmodule

// *** test/can_receive_flag_status_test.sv ***
`timescale 1ns/1ps
module can_receive_flag_status_test
    import rx_flag_pkg::*;
;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic        act, ovr, push, push_good, activity, overrun, pending, good, init_ack;
    logic [8:0]  tx, rx, tx_count, rx_count;
    logic        shift, init_req, sleep, wake_irq, error_irq, rx_irq;
    int          err_count, comparisons;
    logic [8:0]  tx_t [7] = '{9'h060, 9'h000, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h000};
    logic [8:0]  rx_t [7] = '{9'h060, 9'h061, 9'h07F, 9'h080, 9'h000, 9'h0C8, 9'h000};
    logic [7:0]  ctl  [3] = '{8'h01, 8'h02, 8'h03};  // wake enable / sleep combos

    can_receive_flag_status uut (.I_REF_CLK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_BUS_ACTIVITY(activity), .I_OVERRUN(overrun), .I_MSG_PENDING(pending), .I_MSG_GOOD(good),
        .I_TX_ERROR_COUNT(tx_count), .I_RX_ERROR_COUNT(rx_count), .I_INIT_MODE_ACK(init_ack),
        .O_SHIFT(shift), .O_INIT_MODE_REQUEST(init_req), .O_SLEEP(sleep), .O_WAKE_IRQ(wake_irq),
        .O_ERROR_IRQ(error_irq), .O_RX_IRQ(rx_irq));
    engine_model eng (.i_clk(clk), .i_shift(shift), .i_init_req(init_req), .i_act(act), .i_ovr(ovr),
        .i_push(push), .i_push_good(push_good), .i_tx(tx), .i_rx(rx), .o_activity(activity),
        .o_overrun(overrun), .o_pending(pending), .o_good(good), .o_tx_count(tx_count),
        .o_rx_count(rx_count), .o_init_ack(init_ack));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {awaddr, wdata} <= {a, 24'h000000, d};
        {awvalid, wvalid, bready} <= 3'h7;
        forever begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if ((bvalid && !awvalid && !wvalid) || n > 50) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n > 50) err_count++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if ((rvalid && !arvalid) || n > 50) begin
                {rd, rsp} = {rdata, rresp};
                rready <= 1'b0;
                break;
            end
        end
        if (n > 50) err_count++;
        check(rd, exp);
    endtask
    // one-cycle event: 0 overrun, 1 bus activity, 2 message push
    task automatic pulse(input int w);
        @(posedge clk);
        {ovr, act, push} <= {w == 0, w == 1, w == 2};
        @(posedge clk);
        {ovr, act, push} <= 3'h0;
        tick(2);
    endtask
    // expected {rx state, tx state}; receiver shows bus-off with the transmitter
    function automatic logic [3:0] st(input logic [8:0] t, input logic [8:0] r);
        logic [1:0] rs, ts;
        rs = (r > 9'h07F) ? 2'h2 : (r > 9'h060) ? 2'h1 : 2'h0;
        ts = (t > 9'h0FF) ? 2'h3 : (t > 9'h07F) ? 2'h2 : (t > 9'h060) ? 2'h1 : 2'h0;
        return {(t > 9'h0FF) ? 2'h3 : rs, ts};
    endfunction
    task automatic results;
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, reset, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, act, ovr, push, push_good} = 10'h200;
        {awaddr, araddr, wdata, tx, rx} = 66'h0;
        wstrb = 4'hF;
        {err_count, comparisons} = 64'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    end
    // whole run is a few hundred cycles; 20000 cycles means a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin : main
        logic [3:0] prev, exp_st;
        prev = 4'h0;
        @(negedge rst);
        tick(1);
        rchk(ADDR_FLAGS, 32'h0);
        // threshold walk; writing ones to the state bits must not stick
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            {tx, rx} <= {tx_t[i], rx_t[i]};
            tick(3);
            exp_st = st(tx_t[i], rx_t[i]);
            rchk(ADDR_FLAGS, {24'h000000, 1'b0, exp_st != prev, exp_st, 2'h0});
            rchk(ADDR_COUNTERS, {7'h00, tx_t[i], 7'h00, rx_t[i]});
            wr(ADDR_FLAGS, 8'h7C);
            rchk(ADDR_FLAGS, {24'h000000, 2'h0, exp_st, 2'h0});
            prev = exp_st;
        end
        // overrun, masking, zero writes, set beating clear
        pulse(0);
        rchk(ADDR_FLAGS, 32'h00000002);
        check({31'h0, error_irq}, 32'h0);
        wr(ADDR_MASK, 8'h42);
        rchk(ADDR_MASK, 32'h00000042);
        check({31'h0, error_irq}, 32'h1);
        wr(ADDR_FLAGS, 8'h00);
        rchk(ADDR_FLAGS, 32'h00000002);
        ovr <= 1'b1;
        wr(ADDR_FLAGS, 8'h02);
        rchk(ADDR_FLAGS, 32'h00000002);
        ovr <= 1'b0;
        wr(ADDR_FLAGS, 8'h02);
        rchk(ADDR_FLAGS, 32'h0);
        // state fields frozen while the change flag stands
        tx <= 9'h061;
        tick(3);
        tx <= 9'h080;
        tick(3);
        rchk(ADDR_FLAGS, 32'h00000044);
        check({31'h0, error_irq}, 32'h1);
        wr(ADDR_FLAGS, 8'h40);
        rchk(ADDR_FLAGS, 32'h00000048);
        wr(ADDR_FLAGS, 8'h40);
        rchk(ADDR_FLAGS, 32'h00000008);
        // wake flag only when sleeping with detection enabled
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, ctl[i]);
            check({31'h0, sleep}, {31'h0, ctl[i][1]});
            pulse(1);
            rchk(ADDR_FLAGS, {24'h000000, ctl[i] == 8'h03, 7'h08});
        end
        check({31'h0, wake_irq}, 32'h0);
        wr(ADDR_MASK, 8'hC3);
        check({31'h0, wake_irq}, 32'h1);
        wr(ADDR_FLAGS, 8'h80);
        rchk(ADDR_FLAGS, 32'h00000008);
        check({31'h0, wake_irq}, 32'h0);
        wr(ADDR_CTRL, 8'h00);
        // bad message dropped, then two good ones queued
        push_good <= 1'b0;
        pulse(2);
        rchk(ADDR_FLAGS, 32'h00000008);
        push_good <= 1'b1;
        pulse(2);
        pulse(2);
        rchk(ADDR_FLAGS, 32'h00000009);
        check({31'h0, rx_irq}, 32'h1);
        check({31'h0, pending}, 32'h1);
        // host releases the buffer after taking the message
        // next message shifts in only once full clears
        wr(ADDR_FLAGS, 8'h01);
        rchk(ADDR_FLAGS, 32'h00000009);
        check({31'h0, pending}, 32'h0);
        wr(ADDR_FLAGS, 8'h01);
        rchk(ADDR_FLAGS, 32'h00000008);
        check({31'h0, rx_irq}, 32'h0);
        // init mode holds flags and masks, state fields kept
        pulse(0);
        wr(ADDR_CTRL, 8'h04);
        check({31'h0, init_req}, 32'h1);
        tick(3);
        rchk(ADDR_FLAGS, 32'h00000008);
        rchk(ADDR_CTRL, 32'h0000000C);
        rchk(ADDR_MASK, 32'h0);
        wr(ADDR_MASK, 8'h02);
        pulse(0);
        rchk(ADDR_MASK, 32'h0);
        rchk(ADDR_FLAGS, 32'h00000008);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MASK, 8'h02);
        check({30'h0, rsp}, {30'h0, RESP_OKAY});
        rchk(ADDR_MASK, 32'h00000002);
        // unmapped place
        wr(8'h10, 8'hFF);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rchk(8'h10, 32'h0);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        results();
    end
endmodule
